/* inc/abt_params.svh */
/*
 * Constants of the block-protocol APDU transport: status-word codes,
 * interface number limits and default sizes.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef ABT_PARAMS_SVH
`define ABT_PARAMS_SVH

// ----------------------------------------------------------------------
// status words
// ----------------------------------------------------------------------
`define ABT_SW1_WARN_A 8'h62
`define ABT_SW1_WARN_B 8'h63
`define ABT_SW1_APP_HI 4'h9
`define ABT_SW1_OK 8'h90
`define ABT_SW2_OK 8'h00
`define ABT_SW1_PROACTIVE 8'h91
`define ABT_SW1_TK_BUSY 8'h93
`define ABT_SW2_TK_BUSY 8'h00

// ----------------------------------------------------------------------
// interfaces and sizes
// ----------------------------------------------------------------------
`define ABT_IF_MAX 5'h1F
`define ABT_IF_RESET 5'h00
`define ABT_RSP_DEPTH 256
`define ABT_IFS_DEFAULT 32
`define ABT_SW_BYTES 2

`endif

/* inc/abt_pkg.sv */
/*
 * Types shared by the block-protocol APDU transport modules.
 * Assumes abt_params.svh on the include path.
 */
`include "abt_params.svh"

package abt_pkg;

    // one information-field byte of a received block
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic more;
        logic [4:0] ifnum;
        logic [7:0] data;
    } abt_rx_t;

    // one information-field byte of a block to be sent
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic more;
        logic [4:0] ifnum;
        logic [7:0] data;
    } abt_tx_t;

    // one byte of a command handed to the card application
    typedef struct packed {
        logic valid;
        logic last;
        logic [4:0] ifnum;
        logic [7:0] data;
    } abt_cmd_t;

    // completion report from the card application
    typedef struct packed {
        logic done;
        logic envelope;
        logic tk_busy;
        logic [7:0] pending_len;
        logic [7:0] sw1;
        logic [7:0] sw2;
    } abt_done_t;

    typedef enum logic [3:0] {
        ABT_IDLE = 4'h1,
        ABT_RXCMD = 4'h2,
        ABT_PROC = 4'h4,
        ABT_TXRSP = 4'h8
    } abt_state_t;

endpackage : abt_pkg

/* verilog/abt_rsp_mem.sv */
/*
 * Response data buffer: one write port, one read port, registered read.
 * Assumes a single clock and that writer and reader never overlap.
 */
`timescale 1ns/1ps
`include "abt_params.svh"

module abt_rsp_mem #(
    parameter int DEPTH = `ABT_RSP_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : abt_rsp_mem

/* verilog/abt_sw_filter.sv */
/*
 * Status-word selection: toolkit overrides and the data-return decision.
 * Assumes inputs held stable while the completion report is sampled.
 */
`timescale 1ns/1ps
`include "abt_params.svh"

module abt_sw_filter
    import abt_pkg::*;
(
    input abt_done_t rpt,
    output logic [7:0] sw1,
    output logic [7:0] sw2,
    output logic data_ok
);

    logic is_ok;

    assign is_ok = (rpt.sw1 == `ABT_SW1_OK) && (rpt.sw2 == `ABT_SW2_OK);

    always_comb begin
        sw1 = rpt.sw1;
        sw2 = rpt.sw2;
        if (rpt.envelope && rpt.tk_busy) begin
            sw1 = `ABT_SW1_TK_BUSY;
            sw2 = `ABT_SW2_TK_BUSY;
        end else if (is_ok && (rpt.pending_len != 8'h00)) begin
            sw1 = `ABT_SW1_PROACTIVE;
            sw2 = rpt.pending_len;
        end
    end

    // data only with warning, application or success status
    // an envelope refused by a busy toolkit carries status only
    assign data_ok = !(rpt.envelope && rpt.tk_busy)
        && ((sw1 == `ABT_SW1_WARN_A) || (sw1 == `ABT_SW1_WARN_B)
        || (sw1[7:4] == `ABT_SW1_APP_HI));

endmodule : abt_sw_filter

/* verilog/abt_transport.sv */
/*
 * Card-side block-protocol APDU transport: unpacks command information
 * fields, tracks the logical interface, buffers response data and sends
 * it back in chained blocks ending in the status word.
 * Assumes a block framer on the link side and the card application on
 * the user side, both on mclk.
 */
// Functional notes
// - response data only with 62XX, 63XX, 9XXX status; else status only
// - one exchange on an interface is never interleaved with another's blocks
// - response goes in one block or a chain of blocks
// - all four data cases handled: none, response, command, both
// - success may be replaced by 91XX when a proactive command waits
// - envelope with toolkit busy answers 9300
// - interface support is announced in the answer to reset
// - interfaces numbered from zero, never above 1F
// - management selection mandatory on T=0, optional on T=1
// - interface zero is selected right after parameter selection
`timescale 1ns/1ps
`include "abt_params.svh"

module abt_transport
    import abt_pkg::*;
#(
    parameter int IFS = `ABT_IFS_DEFAULT,
    parameter int DEPTH = `ABT_RSP_DEPTH,
    parameter logic [4:0] IF_LAST = `ABT_IF_MAX
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic if_support_strap,
    input wire logic pps_done,
    input wire logic session_if_en,
    input wire logic nad_sel_en,
    input wire logic mgmt_sel_valid,
    input wire logic [4:0] mgmt_sel_if,
    input abt_rx_t rx,
    output abt_cmd_t cmd,
    input wire logic rsp_wr_valid,
    input wire logic [7:0] rsp_wr_data,
    input abt_done_t rpt,
    output abt_tx_t tx,
    input wire logic tx_ready,
    output logic atr_if_support,
    output logic [4:0] cur_if,
    output logic busy,
    output logic err_interleave,
    output logic err_if_range,
    output logic rsp_overflow
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 2;
    localparam logic [CW-1:0] IFS_LAST = CW'(IFS - 1);
    localparam logic [CW-1:0] SW_N = CW'(`ABT_SW_BYTES);

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    logic strap_done_q;
    logic strap_done_d;
    logic support_q;
    logic support_d;

    always_comb begin
        strap_done_d = 1'b1;
        support_d = strap_done_q ? support_q : if_support_strap;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_done_q <= 1'b0;
            support_q <= 1'b0;
        end else begin
            strap_done_q <= strap_done_d;
            support_q <= support_d;
        end
    end

    assign atr_if_support = support_q;

    // ------------------------------------------------------------------
    // status selection
    // ------------------------------------------------------------------
    logic [7:0] f_sw1;
    logic [7:0] f_sw2;
    logic f_data_ok;

    abt_sw_filter u_filter (
        .rpt(rpt),
        .sw1(f_sw1),
        .sw2(f_sw2),
        .data_ok(f_data_ok)
    );

    // ------------------------------------------------------------------
    // exchange state
    // ------------------------------------------------------------------
    abt_state_t state_q;
    abt_state_t state_d;
    logic [4:0] if_q;
    logic [4:0] if_d;
    logic [AW:0] wr_ptr_q;
    logic [AW:0] wr_ptr_d;
    logic [CW-1:0] total_q;
    logic [CW-1:0] total_d;
    logic [CW-1:0] idx_q;
    logic [CW-1:0] idx_d;
    logic [CW-1:0] blk_q;
    logic [CW-1:0] blk_d;
    logic [AW:0] dlen_q;
    logic [AW:0] dlen_d;
    logic [7:0] sw1_q;
    logic [7:0] sw1_d;
    logic [7:0] sw2_q;
    logic [7:0] sw2_d;
    abt_cmd_t cmd_q;
    abt_cmd_t cmd_d;
    logic ilv_q;
    logic ilv_d;
    logic rng_q;
    logic rng_d;
    logic ovf_q;
    logic ovf_d;

    logic if_active;
    logic rx_if_bad;
    logic rx_foreign;
    logic tx_fire;
    logic tx_final;
    logic blk_end;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic mem_wr;

    // address-byte selection only once the session has agreed to it
    assign if_active = session_if_en && nad_sel_en;
    assign rx_if_bad = if_active && (rx.ifnum > IF_LAST);
    assign rx_foreign = if_active && (rx.ifnum != if_q);
    assign tx_fire = tx.valid && tx_ready;
    assign tx_final = (idx_q == total_q - CW'(1));
    assign blk_end = (blk_q == IFS_LAST) || tx_final;
    assign mem_wr = rsp_wr_valid && (state_q == ABT_PROC)
        && (wr_ptr_q < (AW+1)'(DEPTH));

    always_comb begin
        state_d = state_q;
        if_d = if_q;
        wr_ptr_d = wr_ptr_q;
        total_d = total_q;
        idx_d = idx_q;
        blk_d = blk_q;
        dlen_d = dlen_q;
        sw1_d = sw1_q;
        sw2_d = sw2_q;
        cmd_d = '0;
        ilv_d = 1'b0;
        rng_d = 1'b0;
        ovf_d = 1'b0;

        // interface zero after parameter selection
        if (pps_done && session_if_en) begin
            if_d = `ABT_IF_RESET;
        end else if (mgmt_sel_valid && session_if_en
                     && state_q == ABT_IDLE) begin
            if (mgmt_sel_if > IF_LAST) begin
                rng_d = 1'b1;
            end else begin
                if_d = mgmt_sel_if;
            end
        end

        case (state_q)
            ABT_IDLE: begin
                if (rx.valid && rx.first) begin
                    if (rx_if_bad) begin
                        rng_d = 1'b1;
                    end else begin
                        if (if_active) begin
                            if_d = rx.ifnum;
                        end
                        cmd_d.valid = 1'b1;
                        cmd_d.data = rx.data;
                        cmd_d.ifnum = if_active ? rx.ifnum : if_q;
                        cmd_d.last = rx.last && !rx.more;
                        wr_ptr_d = '0;
                        state_d = (rx.last && !rx.more) ? ABT_PROC : ABT_RXCMD;
                    end
                end
            end
            ABT_RXCMD: begin
                // chained command blocks pass through unchanged
                if (rx.valid) begin
                    if (rx_foreign) begin
                        ilv_d = 1'b1;
                    end else begin
                        cmd_d.valid = 1'b1;
                        cmd_d.data = rx.data;
                        cmd_d.ifnum = if_q;
                        cmd_d.last = rx.last && !rx.more;
                        if (rx.last && !rx.more) begin
                            state_d = ABT_PROC;
                        end
                    end
                end
            end
            ABT_PROC: begin
                if (rx.valid && rx_foreign) begin
                    ilv_d = 1'b1;
                end
                if (rsp_wr_valid && !mem_wr) begin
                    ovf_d = 1'b1;
                end
                if (mem_wr) begin
                    wr_ptr_d = wr_ptr_q + (AW+1)'(1);
                end
                if (rpt.done) begin
                    sw1_d = f_sw1;
                    sw2_d = f_sw2;
                    dlen_d = f_data_ok ? wr_ptr_q : '0;
                    total_d = (f_data_ok ? CW'(wr_ptr_q) : '0) + SW_N;
                    idx_d = '0;
                    blk_d = '0;
                    state_d = ABT_TXRSP;
                end
            end
            ABT_TXRSP: begin
                if (rx.valid && rx_foreign) begin
                    ilv_d = 1'b1;
                end
                if (tx_fire) begin
                    idx_d = idx_q + CW'(1);
                    blk_d = blk_end ? '0 : blk_q + CW'(1);
                    if (tx_final) begin
                        state_d = ABT_IDLE;
                    end
                end
            end
            default: begin
                state_d = ABT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ABT_IDLE;
            if_q <= `ABT_IF_RESET;
            wr_ptr_q <= '0;
            total_q <= '0;
            idx_q <= '0;
            blk_q <= '0;
            dlen_q <= '0;
            sw1_q <= 8'h00;
            sw2_q <= 8'h00;
            cmd_q <= '0;
            ilv_q <= 1'b0;
            rng_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if_q <= if_d;
            wr_ptr_q <= wr_ptr_d;
            total_q <= total_d;
            idx_q <= idx_d;
            blk_q <= blk_d;
            dlen_q <= dlen_d;
            sw1_q <= sw1_d;
            sw2_q <= sw2_d;
            cmd_q <= cmd_d;
            ilv_q <= ilv_d;
            rng_q <= rng_d;
            ovf_q <= ovf_d;
        end
    end

    // ------------------------------------------------------------------
    // response buffer and block output
    // ------------------------------------------------------------------
    // prefetch the next byte so the registered read matches idx_q
    assign rd_addr = (state_q != ABT_TXRSP) ? '0 :
        (tx_fire ? AW'(idx_q + CW'(1)) : AW'(idx_q));

    abt_rsp_mem #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .mclk(mclk),
        .wr_en(mem_wr),
        .wr_addr(wr_ptr_q[AW-1:0]),
        .wr_data(rsp_wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    always_comb begin
        tx = '0;
        tx.valid = (state_q == ABT_TXRSP);
        tx.ifnum = if_q;
        tx.first = (state_q == ABT_TXRSP) && (blk_q == '0);
        tx.last = (state_q == ABT_TXRSP) && blk_end;
        // chain bit on every block but the final one
        tx.more = (state_q == ABT_TXRSP)
            && ((total_q - idx_q + blk_q) > CW'(IFS));
        if (state_q == ABT_TXRSP) begin
            if (idx_q < CW'(dlen_q)) begin
                tx.data = rd_data;
            end else if (idx_q == CW'(dlen_q)) begin
                tx.data = sw1_q;
            end else begin
                tx.data = sw2_q;
            end
        end
    end

    assign cmd = cmd_q;
    assign cur_if = if_q;
    assign busy = (state_q != ABT_IDLE);
    assign err_interleave = ilv_q;
    assign err_if_range = rng_q;
    assign rsp_overflow = ovf_q;

endmodule : abt_transport

/* tb/abt_transport_asserts.sv */
/*
 * Port-level checks of the APDU transport.
 * Assumes abt_pkg compiled first; bound to every abt_transport.
 */
`timescale 1ns/1ps

module abt_transport_asserts
    import abt_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic if_support_strap,
    input wire logic pps_done,
    input wire logic session_if_en,
    input wire logic nad_sel_en,
    input abt_rx_t rx,
    input abt_cmd_t cmd,
    input abt_done_t rpt,
    input abt_tx_t tx,
    input wire logic tx_ready,
    input wire logic atr_if_support,
    input wire logic [4:0] cur_if,
    input wire logic busy,
    input wire logic err_interleave
);
    logic [1:0] up_q;
    logic [1:0] up_d;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // edges since reset release, saturating at 3
    // ------------------------------------------------------------------
    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 2'h0;
        end else begin
            up_q <= up_d;
        end
    end

    sequence s_done_idle;
        rpt.done && busy && !tx.valid;
    endsequence

    sequence s_final_taken;
        tx.valid && tx.last && !tx.more && tx_ready;
    endsequence

    a_cmd_echo: assert property (
        rx.valid && rx.first && !busy |=>
        cmd.valid && cmd.data == $past(rx.data))
        else $error("first command byte not passed on");
    a_tx_hold: assert property (
        tx.valid && !tx_ready |=>
        tx.valid && $stable(tx.data) && $stable(tx.last))
        else $error("response byte changed before taken");
    a_tk_busy: assert property (
        s_done_idle ##0 rpt.envelope && rpt.tk_busy |=>
        tx.valid && tx.first && tx.data == 8'h93)
        else $error("toolkit busy status not sent first");
    a_plain_sw: assert property (
        s_done_idle ##0 !(rpt.envelope && rpt.tk_busy) &&
        rpt.sw1 != 8'h62 && rpt.sw1 != 8'h63 && rpt.sw1[7:4] != 4'h9 |=>
        tx.valid && tx.first && tx.data == $past(rpt.sw1))
        else $error("data sent with a non-data status");
    a_resp_end: assert property (
        s_final_taken |=> !busy && !tx.valid)
        else $error("response did not end after final byte");
    a_pps_zero: assert property (
        pps_done && session_if_en |=> cur_if == 5'h00)
        else $error("interface zero not selected after parameters");
    a_atr_take: assert property (
        up_q == 2'h2 |-> atr_if_support == $past(if_support_strap, 2))
        else $error("support flag not taken from strap");
    a_atr_hold: assert property (
        up_q == 2'h3 |-> $stable(atr_if_support))
        else $error("support flag changed during session");
    a_drop_cause: assert property (
        err_interleave |-> $past(rx.valid) && $past(nad_sel_en) && !cmd.valid)
        else $error("interleave flag without a foreign byte");
endmodule : abt_transport_asserts

bind abt_transport abt_transport_asserts u_abt_chk (
    .mclk(mclk), .resetn(resetn), .if_support_strap(if_support_strap),
    .pps_done(pps_done), .session_if_en(session_if_en),
    .nad_sel_en(nad_sel_en), .rx(rx), .cmd(cmd), .rpt(rpt), .tx(tx),
    .tx_ready(tx_ready), .atr_if_support(atr_if_support), .cur_if(cur_if),
    .busy(busy), .err_interleave(err_interleave));

/* tb/abt_term_model.sv */
/*
 * Terminal transport model: sends command blocks, takes response bytes.
 * Assumes the bench calls send at a falling edge and drives stall.
 */
`timescale 1ns/1ps

module abt_term_model
    import abt_pkg::*;
#(
    parameter int IFS = 4
) (
    input wire logic mclk,
    input wire logic stall,
    output abt_rx_t rx,
    output logic tx_ready
);
    assign tx_ready = !stall;

    initial rx = '0;

    // fin low leaves the chain open after the final block
    task automatic send(input logic [7:0] b[$], input logic [4:0] ifn,
                        input logic fin);
        int n;
        logic lst;
        n = b.size();
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            lst = (i % IFS == IFS - 1) || (i == n - 1);
            rx = '{1'b1, i % IFS == 0, lst, lst && (i != n - 1 || !fin),
                   ifn, b[i]};
        end
        @(negedge mclk);
        rx.valid = 1'b0;
        rx.data = ~rx.data;
    endtask : send
endmodule : abt_term_model

/* tb/tb_abt_transport.sv */
/*
 * Self-checking bench: all data cases, toolkit status, overflow, interleave.
 * Assumes package, design and terminal model compiled before it.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))

module tb_abt_transport;
    import abt_pkg::*;
    localparam int IFS = 4;
    localparam int DEPTH = 16;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b1;
    logic pps_done = 1'b0;
    logic sess = 1'b1;
    logic nad = 1'b0;
    logic mg_v = 1'b0;
    logic [4:0] mg_if = 5'h00;
    logic wr_v = 1'b0;
    logic [7:0] wr_d = 8'h00;
    logic stall = 1'b0;
    logic [7:0] rnd = 8'h47;
    logic [7:0] sr = 8'h47;
    abt_rx_t rx;
    abt_cmd_t cmd;
    abt_done_t rpt = '0;
    abt_tx_t tx;
    logic tx_ready, atr, busy, err_il, ovf, rng;
    int n_rg = 0;
    logic [4:0] cur_if;
    logic [15:0] exp_cmd[$];
    logic [15:0] exp_tx[$];
    logic [7:0] c[$];
    int error_cnt = 0;
    int num_checks = 0;
    int n_il = 0;
    int n_ov = 0;

    always #4 mclk = ~mclk;

    abt_term_model #(.IFS(IFS)) u_term (.mclk(mclk), .stall(stall),
        .rx(rx), .tx_ready(tx_ready));

    abt_transport #(.IFS(IFS), .DEPTH(DEPTH)) DUT (
        .mclk(mclk), .resetn(resetn), .if_support_strap(strap),
        .pps_done(pps_done), .session_if_en(sess), .nad_sel_en(nad),
        .mgmt_sel_valid(mg_v), .mgmt_sel_if(mg_if), .rx(rx), .cmd(cmd),
        .rsp_wr_valid(wr_v), .rsp_wr_data(wr_d), .rpt(rpt), .tx(tx),
        .tx_ready(tx_ready), .atr_if_support(atr), .cur_if(cur_if),
        .busy(busy), .err_interleave(err_il), .err_if_range(rng),
        .rsp_overflow(ovf));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic settle(input logic idle);
        for (int k = 0; k < 500 && !(exp_cmd.size() == 0 &&
             exp_tx.size() == 0 && (!idle || busy === 1'b0)); k++)
            @(negedge mclk);
        repeat (2) @(negedge mclk);
    endtask : settle

    task automatic mk(input int nc, input logic [4:0] ifn);
        c.delete();
        for (int i = 0; i < nc; i++) begin
            rnd = lfsr(rnd);
            c.push_back(rnd);
            exp_cmd.push_back({2'b00, i == nc - 1, ifn, rnd});
        end
    endtask : mk

    task automatic rsp(input int nd, input logic [7:0] s1,
                       input logic [7:0] s2, input logic env,
                       input logic tkb, input logic [7:0] pend);
        logic [7:0] r[$];
        logic lst;
        for (int i = 0; i < nd; i++) begin
            @(negedge mclk);
            rnd = lfsr(rnd);
            wr_v = 1'b1;
            wr_d = rnd;
            if (i < DEPTH) r.push_back(rnd);
        end
        @(negedge mclk);
        wr_v = 1'b0;
        @(negedge mclk);
        rpt = '{1'b1, env, tkb, pend, s1, s2};
        if (env && tkb) begin
            {s1, s2} = 16'h9300;
            r.delete();
        end else if ({s1, s2} == 16'h9000 && pend != 8'h00) begin
            {s1, s2} = {8'h91, pend};
        end
        if (s1 != 8'h62 && s1 != 8'h63 && s1[7:4] != 4'h9) r.delete();
        r.push_back(s1);
        r.push_back(s2);
        for (int i = 0; i < r.size(); i++) begin
            lst = (i % IFS == IFS - 1) || (i == r.size() - 1);
            exp_tx.push_back({6'h00, lst, lst && i != r.size() - 1, r[i]});
        end
        @(negedge mclk);
        rpt.done = 1'b0;
        settle(1'b1);
    endtask : rsp

    task automatic xchg(input int nc, input int nd, input logic [7:0] s1,
                        input logic [7:0] s2, input logic env,
                        input logic tkb, input logic [7:0] pend);
        mk(nc, 5'h00);
        u_term.send(c, 5'h00, 1'b1);
        settle(1'b0);
        rsp(nd, s1, s2, env, tkb, pend);
    endtask : xchg

    // ------------------------------------------------------------------
    // result watcher and far-side stalls
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (err_il === 1'b1) n_il++;
        if (ovf === 1'b1) n_ov++;
        if (rng === 1'b1) n_rg++;
        if (cmd.valid === 1'b1) begin
            `CHK("cmd", exp_cmd.pop_front(), {cmd.last, cmd.ifnum, cmd.data});
        end
        if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
            `CHK("tx", exp_tx.pop_front(), {tx.last, tx.last & tx.more, tx.data});
        end
    end

    always @(negedge mclk) begin
        sr <= lfsr(sr);
        stall <= sr[0] & sr[2];
    end

    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("atr", 1'b1, atr);
        mg_v = 1'b1;
        mg_if = 5'h02;
        @(negedge mclk);
        mg_v = 1'b0;
        @(negedge mclk);
        `CHK("mgmt if", 5'h02, cur_if);
        pps_done = 1'b1;
        @(negedge mclk);
        pps_done = 1'b0;
        @(negedge mclk);
        `CHK("pps if", 5'h00, cur_if);
        xchg(4, 0, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        xchg(9, 6, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        xchg(5, 3, 8'h90, 8'h00, 1'b0, 1'b0, 8'h15);
        xchg(6, 3, 8'h90, 8'h00, 1'b1, 1'b1, 8'h00);
        xchg(5, 2, 8'h90, 8'h00, 1'b1, 1'b0, 8'h00);
        xchg(5, 2, 8'h62, 8'h81, 1'b1, 1'b0, 8'h00);
        xchg(5, 2, 8'h63, 8'hC1, 1'b0, 1'b0, 8'h00);
        xchg(5, 2, 8'h9F, 8'h10, 1'b0, 1'b0, 8'h00);
        xchg(5, 2, 8'h6F, 8'h00, 1'b1, 1'b0, 8'h00);
        xchg(4, 17, 8'h90, 8'h00, 1'b0, 1'b0, 8'h00);
        `CHK("overflow", 1, n_ov);
        `CHK("range", 0, n_rg);
        // address byte only once support and configuration are confirmed
        nad = 1'b1;
        mk(6, 5'h01);
        u_term.send(c[0:3], 5'h01, 1'b0);
        u_term.send(c[0:1], 5'h03, 1'b1);
        u_term.send(c[4:5], 5'h01, 1'b1);
        settle(1'b0);
        `CHK("foreign drop", 1'b1, n_il != 0);
        rsp(2, 8'h6A, 8'h82, 1'b0, 1'b0, 8'h00);
        print_verdict();
    end
endmodule : tb_abt_transport
